/* File: sea_ctrl_model.sv */
// remote controller model: issues commands and fetches replies
`timescale 1ns/10ps
module sea_ctrl_model (
   input wire logic sys_clk,
   input wire logic rsp_valid_ff,
   input wire logic [15:0] rsp_data_ff,
   output logic cmd_valid,
   output sea_pkg::sea_cmd_type cmd,
   output logic rsp_read
);
   initial begin
      cmd_valid = 1'h0;
      cmd = '0;
      rsp_read = 1'h0;
   end
   // released command lines are scrambled so stale values never match
   task automatic issue(input sea_pkg::sea_op_type op,
         input sea_pkg::sea_reg_type sel, input logic [15:0] data);
      @(negedge sys_clk);
      cmd_valid = 1'h1;
      cmd = '{op: op, sel: sel, data: data};
      @(negedge sys_clk);
      cmd_valid = 1'h0;
      cmd = ~cmd;
   endtask : issue
   task automatic fetch(output logic [15:0] data, output logic got);
      for (int i = 0; i < 4 && rsp_valid_ff !== 1'h1; i++)
         @(negedge sys_clk);
      got = (rsp_valid_ff === 1'h1);
      data = rsp_data_ff;
      if (got) begin
         rsp_read = 1'h1;
         @(negedge sys_clk);
         rsp_read = 1'h0;
      end
   endtask : fetch
   // fetch strobe with no reply pending, a controller slip on purpose
   task automatic stray();
      @(negedge sys_clk);
      rsp_read = 1'h1;
      @(negedge sys_clk);
      rsp_read = 1'h0;
   endtask : stray
endmodule : sea_ctrl_model

/* File: sea_params.svh */
// constants of the status event aggregator
`ifndef SEA_PARAMS_SVH
`define SEA_PARAMS_SVH
`define SEA_ESR_OPC 0
`define SEA_ESR_QRY 2
`define SEA_ESR_DEV 3
`define SEA_ESR_EXE 4
`define SEA_ESR_CMD 5
`define SEA_ESR_PON 7
`define SEA_ESR_RST 8'h80
`define SEA_ESR_USED 8'hBD
`define SEA_ENA_RST 16'h0000
`define SEA_ESE_RST 8'h00
`define SEA_PPE_RST 8'h00
`define SEA_QUES_INT 9
`define SEA_QUES_LIM 10
`define SEA_QUES_USED 16'h0600
`define SEA_LIM1_SUM 0
`define SEA_LIM1_USED 16'h7FFF
`define SEA_LIM1_TRACES 14
`define SEA_LIM2_T15 1
`define SEA_LIM2_T16 2
`define SEA_LIM2_USED 16'h0006
`define SEA_MAX_TRACES 16
`define SEA_ERR_DEV 16'hFEA2
`define SEA_ERR_EXE 16'hFF38
`define SEA_ERR_CMD 16'hFF9C
`endif

/* File: sea_pkg.sv */
// types of the status event aggregator
package sea_pkg;
   typedef enum logic [2:0] {
      SEA_OP_SET_ENA, SEA_OP_GET_ENA, SEA_OP_GET_COND,
      SEA_OP_GET_EVT, SEA_OP_OPC, SEA_OP_GET_IST
   } sea_op_type;
   typedef enum logic [2:0] {
      SEA_REG_STD, SEA_REG_PP, SEA_REG_OPER,
      SEA_REG_QUES, SEA_REG_LIM1, SEA_REG_LIM2
   } sea_reg_type;
   typedef struct packed {
      sea_op_type op;
      sea_reg_type sel;
      logic [15:0] data;
   } sea_cmd_type;
   typedef struct packed {
      logic opc_busy;
      logic dev_err;
      logic exe_err;
      logic cmd_err;
   } sea_evt_type;
endpackage : sea_pkg

/* File: sea_status_agg.sv */
// status event aggregator: ist, event status and questionable chain
`timescale 1ns/10ps
`include "sea_params.svh"
module sea_status_agg #(
   parameter int TRACE_IN = 16
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic cmd_valid,
   input wire sea_pkg::sea_cmd_type cmd,
   input wire logic rsp_read,
   input wire sea_pkg::sea_evt_type evt,
   input wire logic [7:0] stb_in,
   input wire logic [15:0] integ_event,
   input wire logic [15:0] integ_enable,
   input wire logic [TRACE_IN-1:0] trace_fail,
   output logic ist_ff,
   output logic esb_ff,
   output logic ques_sum_ff,
   output logic rsp_valid_ff,
   output logic [15:0] rsp_data_ff,
   output logic err_push_ff,
   output logic [15:0] err_code_ff
);
   // traces beyond the monitored count are simply not wired in
   if (TRACE_IN < `SEA_MAX_TRACES) begin : g_chk
      $error("TRACE_IN must be at least 16");
   end

   // index 0..2 = questionable, limit1, limit2
   localparam int NREG = 3;
   localparam logic [15:0] USED [NREG] = '{`SEA_QUES_USED,
      `SEA_LIM1_USED, `SEA_LIM2_USED};

   logic [7:0] esr_ff, nxt_esr, ese_ff, nxt_ese, ppe_ff, nxt_ppe;
   logic opc_pend_ff, nxt_opc_pend;
   logic [15:0] evt_ff [NREG];
   logic [15:0] nxt_evt [NREG];
   logic [15:0] ena_ff [NREG];
   logic [15:0] nxt_ena [NREG];
   logic [15:0] prev_ff [NREG];
   logic [15:0] cond [NREG];
   logic [NREG-1:0] sum;
   logic nxt_ist, nxt_esb, nxt_rsp_valid, nxt_push;
   logic [15:0] nxt_rsp, nxt_code;
   logic [15:0] tr16;

   function automatic int reg_idx(input sea_pkg::sea_reg_type s);
      case (s)
         sea_pkg::SEA_REG_QUES: reg_idx = 0;
         sea_pkg::SEA_REG_LIM1: reg_idx = 1;
         sea_pkg::SEA_REG_LIM2: reg_idx = 2;
         default: reg_idx = -1;
      endcase
   endfunction : reg_idx

   // trace k sits at index k-1, ordered by channel then by age upstream
   assign tr16 = trace_fail[`SEA_MAX_TRACES-1:0];

   // condition parts; the summary chain passes through the registered event parts, one cycle per level
   always_comb begin
      cond[2] = 16'h0000;
      cond[2][`SEA_LIM2_T15] = tr16[14];
      cond[2][`SEA_LIM2_T16] = tr16[15];
      cond[1] = 16'h0000;
      cond[1][`SEA_LIM1_TRACES:1] = tr16[`SEA_LIM1_TRACES-1:0];
      cond[1][`SEA_LIM1_SUM] = sum[2];
      cond[0] = 16'h0000;
      cond[0][`SEA_QUES_INT] = |(integ_event & integ_enable);
      cond[0][`SEA_QUES_LIM] = sum[1];
   end

   for (genvar i = 0; i < NREG; i++) begin : g_sum
      assign sum[i] = |(evt_ff[i] & ena_ff[i] & USED[i]);
   end

   always_comb begin
      int k;
      logic take, rd_evt;
      k = reg_idx(cmd.sel);
      take = cmd_valid;
      rd_evt = 1'b0;
      nxt_esr = esr_ff;
      nxt_ese = ese_ff;
      nxt_ppe = ppe_ff;
      nxt_opc_pend = opc_pend_ff;
      nxt_rsp_valid = rsp_valid_ff & ~rsp_read;
      nxt_rsp = rsp_data_ff;
      nxt_push = 1'b0;
      nxt_code = err_code_ff;
      for (int i = 0; i < NREG; i++) begin
         nxt_evt[i] = evt_ff[i];
         nxt_ena[i] = ena_ff[i];
      end
      if (take) begin
         nxt_rsp_valid = 1'b0;
         case (cmd.op)
            sea_pkg::SEA_OP_SET_ENA: begin
               if (cmd.sel == sea_pkg::SEA_REG_STD) begin
                  nxt_ese = cmd.data[7:0];
               end else if (cmd.sel == sea_pkg::SEA_REG_PP) begin
                  nxt_ppe = cmd.data[7:0];
               end else if (k >= 0) begin
                  nxt_ena[k] = cmd.data;
               end
            end
            sea_pkg::SEA_OP_GET_ENA: begin
               nxt_rsp_valid = 1'b1;
               if (cmd.sel == sea_pkg::SEA_REG_STD) begin
                  nxt_rsp = {8'h00, ese_ff};
               end else if (cmd.sel == sea_pkg::SEA_REG_PP) begin
                  nxt_rsp = {8'h00, ppe_ff};
               end else if (k >= 0) begin
                  nxt_rsp = ena_ff[k];
               end else begin
                  nxt_rsp = 16'h0000;
               end
            end
            sea_pkg::SEA_OP_GET_COND, sea_pkg::SEA_OP_GET_EVT: begin
               nxt_rsp_valid = 1'b1;
               nxt_rsp = 16'h0000;
               if (cmd.sel == sea_pkg::SEA_REG_STD) begin
                  // both views of this register are destructive
                  nxt_rsp = {8'h00, esr_ff};
                  nxt_esr = 8'h00;
               end else if (k >= 0 &&
                            cmd.op == sea_pkg::SEA_OP_GET_COND) begin
                  nxt_rsp = cond[k] & USED[k];
               end else if (k >= 0) begin
                  nxt_rsp = evt_ff[k];
                  rd_evt = 1'b1;
               end
            end
            sea_pkg::SEA_OP_OPC: begin
               nxt_opc_pend = 1'b1;
            end
            sea_pkg::SEA_OP_GET_IST: begin
               nxt_rsp_valid = 1'b1;
               nxt_rsp = {15'h0000, ist_ff};
            end
            default: begin
               nxt_rsp_valid = rsp_valid_ff;
            end
         endcase
      end
      // event parts: read clears first, then rising conditions set
      for (int i = 0; i < NREG; i++) begin
         if (rd_evt && k == i) begin
            nxt_evt[i] = 16'h0000;
         end
         nxt_evt[i] = nxt_evt[i] | (cond[i] & ~prev_ff[i] & USED[i]);
      end
      // esr sets come last so a set beats a same-cycle clearing read
      if (opc_pend_ff && !evt.opc_busy) begin
         nxt_esr[`SEA_ESR_OPC] = 1'b1;
         nxt_opc_pend = 1'b0;
      end
      if ((rsp_read && !rsp_valid_ff) ||
          (take && rsp_valid_ff && !rsp_read)) begin
         nxt_esr[`SEA_ESR_QRY] = 1'b1;
      end
      if (evt.dev_err) begin
         nxt_esr[`SEA_ESR_DEV] = 1'b1;
         nxt_push = 1'b1;
         nxt_code = `SEA_ERR_DEV;
      end
      if (evt.exe_err) begin
         nxt_esr[`SEA_ESR_EXE] = 1'b1;
         nxt_push = 1'b1;
         nxt_code = `SEA_ERR_EXE;
      end
      if (evt.cmd_err) begin
         nxt_esr[`SEA_ESR_CMD] = 1'b1;
         nxt_push = 1'b1;
         nxt_code = `SEA_ERR_CMD;
      end
      nxt_esr = nxt_esr & `SEA_ESR_USED;
      nxt_ese = nxt_ese & `SEA_ESR_USED;
      // esb follows registered state and ist follows the stb_in input, each one cycle behind
      nxt_esb = |(esr_ff & ese_ff);
      nxt_ist = |(stb_in & ppe_ff);
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         esr_ff <= `SEA_ESR_RST;
         ese_ff <= `SEA_ESE_RST;
         ppe_ff <= `SEA_PPE_RST;
         opc_pend_ff <= 1'b0;
         ist_ff <= 1'b0;
         esb_ff <= 1'b0;
         ques_sum_ff <= 1'b0;
         rsp_valid_ff <= 1'b0;
         rsp_data_ff <= 16'h0000;
         err_push_ff <= 1'b0;
         err_code_ff <= 16'h0000;
         for (int i = 0; i < NREG; i++) begin
            evt_ff[i] <= 16'h0000;
            ena_ff[i] <= `SEA_ENA_RST;
            prev_ff[i] <= 16'h0000;
         end
      end else begin
         esr_ff <= nxt_esr;
         ese_ff <= nxt_ese;
         ppe_ff <= nxt_ppe;
         opc_pend_ff <= nxt_opc_pend;
         ist_ff <= nxt_ist;
         esb_ff <= nxt_esb;
         ques_sum_ff <= sum[0];
         rsp_valid_ff <= nxt_rsp_valid;
         rsp_data_ff <= nxt_rsp;
         err_push_ff <= nxt_push;
         err_code_ff <= nxt_code;
         for (int i = 0; i < NREG; i++) begin
            evt_ff[i] <= nxt_evt[i];
            ena_ff[i] <= nxt_ena[i];
            prev_ff[i] <= cond[i] & USED[i];
         end
      end
   end

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!nrst);

   sequence s_esr_read;
      cmd_valid && cmd.op == sea_pkg::SEA_OP_GET_EVT &&
         cmd.sel == sea_pkg::SEA_REG_STD;
   endsequence
   sequence s_quiet;
      !evt.dev_err && !evt.exe_err && !evt.cmd_err &&
         !(opc_pend_ff && !evt.opc_busy) && !rsp_read && !rsp_valid_ff;
   endsequence
   sequence s_lim2_evt_read;
      cmd_valid && cmd.op == sea_pkg::SEA_OP_GET_EVT &&
         cmd.sel == sea_pkg::SEA_REG_LIM2;
   endsequence
   sequence s_lim2_steady;
      cond[2] == prev_ff[2];
   endsequence

   ist_follows_a: assert property (
      ##1 ist_ff == |($past(stb_in) & $past(ppe_ff)))
      else $error("ist mismatch");
   esr_clear_a: assert property (
      s_esr_read and s_quiet |=> esr_ff == 8'h00 &&
      rsp_data_ff == {8'h00, $past(esr_ff)})
      else $error("esr read not destructive");
   esb_set_a: assert property (
      |(esr_ff & ese_ff) |-> ##1 esb_ff)
      else $error("esb missing");
   opc_done_a: assert property (
      opc_pend_ff && !evt.opc_busy |=> esr_ff[`SEA_ESR_OPC])
      else $error("opc bit not set");
   qerr_set_a: assert property (
      rsp_read && !rsp_valid_ff |=> esr_ff[`SEA_ESR_QRY])
      else $error("query error not flagged");
   dev_err_a: assert property (
      evt.dev_err && !evt.exe_err && !evt.cmd_err |=>
      esr_ff[`SEA_ESR_DEV] && err_push_ff && err_code_ff == `SEA_ERR_DEV)
      else $error("device error not reported");
   exe_err_a: assert property (
      evt.exe_err && !evt.cmd_err |=> esr_ff[`SEA_ESR_EXE] &&
      err_push_ff && err_code_ff == `SEA_ERR_EXE)
      else $error("execution error not reported");
   cmd_err_a: assert property (
      evt.cmd_err |=> esr_ff[`SEA_ESR_CMD] && err_push_ff &&
      err_code_ff == `SEA_ERR_CMD)
      else $error("command error not reported");
   esr_unused_a: assert property (
      (esr_ff & ~`SEA_ESR_USED) == 8'h00)
      else $error("unused esr bit set");
   lim_chain_a: assert property (
      $rose(sum[1]) |=> evt_ff[0][`SEA_QUES_LIM])
      else $error("limit summary lost");
   evt_read_a: assert property (
      s_lim2_evt_read and s_lim2_steady |=> evt_ff[2] == 16'h0000 &&
      rsp_data_ff == $past(evt_ff[2]))
      else $error("event part read not cleared");
endmodule : sea_status_agg

/* File: sea_status_agg_tb.sv */
// testbench of the status event aggregator
`timescale 1ns/10ps
module sea_status_agg_tb;
   logic sys_clk, nrst, cmd_valid, rsp_read, ist_ff, esb_ff;
   logic ques_sum_ff, rsp_valid_ff, err_push_ff;
   logic [15:0] rsp_data_ff, err_code_ff, integ_event, integ_enable;
   logic [7:0] stb_in;
   logic [17:0] trace_fail;
   sea_pkg::sea_cmd_type cmd;
   sea_pkg::sea_evt_type evt;
   int fail_count = 0;
   int total_checks = 0;
   sea_status_agg #(.TRACE_IN(18)) dut_u (.sys_clk(sys_clk), .nrst(nrst),
      .cmd_valid(cmd_valid), .cmd(cmd), .rsp_read(rsp_read), .evt(evt),
      .stb_in(stb_in), .integ_event(integ_event),
      .integ_enable(integ_enable), .trace_fail(trace_fail),
      .ist_ff(ist_ff), .esb_ff(esb_ff), .ques_sum_ff(ques_sum_ff),
      .rsp_valid_ff(rsp_valid_ff), .rsp_data_ff(rsp_data_ff),
      .err_push_ff(err_push_ff), .err_code_ff(err_code_ff));
   sea_ctrl_model ctrl_u (.sys_clk(sys_clk), .rsp_valid_ff(rsp_valid_ff),
      .rsp_data_ff(rsp_data_ff), .cmd_valid(cmd_valid), .cmd(cmd),
      .rsp_read(rsp_read));
   initial begin
      sys_clk = 1'h0;
      forever #25 sys_clk = ~sys_clk;
   end
   task automatic tally_and_finish();
      $display("checks=%0d mismatches=%0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic rd(input sea_pkg::sea_op_type op,
         input sea_pkg::sea_reg_type sel, input logic [15:0] exp);
      logic [15:0] d;
      logic got;
      ctrl_u.issue(op, sel, 16'h0000);
      ctrl_u.fetch(d, got);
      if (!got)
         d = 'x;
      chk(d, exp);
   endtask : rd
   // one error pulse, push and code checked in the following cycle
   task automatic ev(input int idx, input logic [15:0] code);
      @(negedge sys_clk);
      evt[idx] = 1'h1;
      @(negedge sys_clk);
      evt[idx] = 1'h0;
      chk({15'h0000, err_push_ff}, 16'h0001);
      chk(err_code_ff, code);
   endtask : ev
   task automatic twait(input int n);
      repeat (n) @(negedge sys_clk);
   endtask : twait
   initial begin
      repeat (3000) @(posedge sys_clk);
      fail_count++;
      tally_and_finish();
   end
   initial begin
      nrst = 1'h0;
      evt = '0;
      stb_in = 8'h00;
      integ_event = 16'h0000;
      integ_enable = 16'h0000;
      trace_fail = 18'h00000;
      twait(20);
      nrst = 1'h1;
      rd(sea_pkg::SEA_OP_GET_EVT, sea_pkg::SEA_REG_STD, 16'h0080);
      rd(sea_pkg::SEA_OP_GET_EVT, sea_pkg::SEA_REG_STD, 16'h0000);
      ctrl_u.issue(sea_pkg::SEA_OP_SET_ENA, sea_pkg::SEA_REG_STD, 16'h0010);
      rd(sea_pkg::SEA_OP_GET_ENA, sea_pkg::SEA_REG_STD, 16'h0010);
      ev(1, 16'hFF38);
      twait(2);
      chk({15'h0000, esb_ff}, 16'h0001);
      ev(0, 16'hFF9C);
      ev(2, 16'hFEA2);
      rd(sea_pkg::SEA_OP_GET_COND, sea_pkg::SEA_REG_STD, 16'h0038);
      twait(2);
      chk({15'h0000, esb_ff}, 16'h0000);
      ctrl_u.issue(sea_pkg::SEA_OP_SET_ENA, sea_pkg::SEA_REG_PP, 16'h0040);
      rd(sea_pkg::SEA_OP_GET_ENA, sea_pkg::SEA_REG_PP, 16'h0040);
      stb_in = 8'h40;
      twait(2);
      chk({15'h0000, ist_ff}, 16'h0001);
      rd(sea_pkg::SEA_OP_GET_IST, sea_pkg::SEA_REG_STD, 16'h0001);
      stb_in = 8'hBF;
      twait(2);
      chk({15'h0000, ist_ff}, 16'h0000);
      ctrl_u.stray();
      rd(sea_pkg::SEA_OP_GET_EVT, sea_pkg::SEA_REG_STD, 16'h0004);
      ctrl_u.issue(sea_pkg::SEA_OP_GET_EVT, sea_pkg::SEA_REG_STD, 16'h0000);
      rd(sea_pkg::SEA_OP_GET_ENA, sea_pkg::SEA_REG_STD, 16'h0010);
      rd(sea_pkg::SEA_OP_GET_EVT, sea_pkg::SEA_REG_STD, 16'h0004);
      evt.opc_busy = 1'h1;
      ctrl_u.issue(sea_pkg::SEA_OP_OPC, sea_pkg::SEA_REG_STD, 16'h0000);
      twait(3);
      rd(sea_pkg::SEA_OP_GET_EVT, sea_pkg::SEA_REG_STD, 16'h0000);
      evt.opc_busy = 1'h0;
      twait(3);
      rd(sea_pkg::SEA_OP_GET_EVT, sea_pkg::SEA_REG_STD, 16'h0001);
      ctrl_u.issue(sea_pkg::SEA_OP_SET_ENA, sea_pkg::SEA_REG_OPER, 16'hFFFF);
      rd(sea_pkg::SEA_OP_GET_COND, sea_pkg::SEA_REG_OPER, 16'h0000);
      // traces 1 and 15 fail; the two beyond sixteen must stay unseen
      trace_fail = 18'h34001;
      twait(4);
      rd(sea_pkg::SEA_OP_GET_COND, sea_pkg::SEA_REG_LIM1, 16'h0002);
      rd(sea_pkg::SEA_OP_GET_COND, sea_pkg::SEA_REG_LIM2, 16'h0002);
      ctrl_u.issue(sea_pkg::SEA_OP_SET_ENA, sea_pkg::SEA_REG_LIM2, 16'h0002);
      ctrl_u.issue(sea_pkg::SEA_OP_SET_ENA, sea_pkg::SEA_REG_LIM1, 16'h0001);
      ctrl_u.issue(sea_pkg::SEA_OP_SET_ENA, sea_pkg::SEA_REG_QUES, 16'h0400);
      twait(6);
      rd(sea_pkg::SEA_OP_GET_COND, sea_pkg::SEA_REG_LIM1, 16'h0003);
      rd(sea_pkg::SEA_OP_GET_COND, sea_pkg::SEA_REG_QUES, 16'h0400);
      chk({15'h0000, ques_sum_ff}, 16'h0001);
      rd(sea_pkg::SEA_OP_GET_EVT, sea_pkg::SEA_REG_LIM2, 16'h0002);
      rd(sea_pkg::SEA_OP_GET_EVT, sea_pkg::SEA_REG_LIM2, 16'h0000);
      integ_event = 16'h0004;
      integ_enable = 16'h0004;
      twait(6);
      // limit summary still latched in the unread first limit event part
      rd(sea_pkg::SEA_OP_GET_COND, sea_pkg::SEA_REG_QUES, 16'h0600);
      tally_and_finish();
   end
endmodule : sea_status_agg_tb
